//--- rtl/gcf_pkg.sv
package gcf_pkg;

  // ---------------------------------------------------------------
  // timing base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;

  // least time in ns rounded up to whole clock cycles, never below one
  function automatic int unsigned cyc_ceil(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ---------------------------------------------------------------
  // command timing limits of the driven device
  // ---------------------------------------------------------------
  localparam int unsigned DEAD_TIME_NS      = 1500;
  localparam int unsigned MIN_PULSE_NS      = 500;
  localparam int unsigned CARRIER_PERIOD_NS = 50000;
  localparam int unsigned SHUT_PULSE_NS     = 6000;
  localparam int unsigned RESPONSE_NS       = 20000;

  localparam int unsigned DEAD_CYC    = cyc_ceil(DEAD_TIME_NS);
  localparam int unsigned MIN_CYC     = cyc_ceil(MIN_PULSE_NS);
  localparam int unsigned CARRIER_CYC = cyc_ceil(CARRIER_PERIOD_NS);
  localparam int unsigned SHUT_CYC    = cyc_ceil(SHUT_PULSE_NS);

  // ---------------------------------------------------------------
  // widths and sized limits
  // ---------------------------------------------------------------
  localparam int unsigned PHASES = 3;
  localparam int unsigned CNT_W  = 11;
  localparam int unsigned TMR_W  = 8;

  localparam logic [CNT_W-1:0] CARRIER_LAST = CNT_W'(CARRIER_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO     = 11'h000;
  localparam logic [TMR_W-1:0] TMR_ZERO     = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE      = 8'h01;
  localparam logic [TMR_W-1:0] DEAD_LAST    = TMR_W'(DEAD_CYC - 1);
  localparam logic [TMR_W-1:0] MIN_LAST     = TMR_W'(MIN_CYC - 1);
  localparam logic [TMR_W-1:0] SHUT_LOAD    = TMR_W'(SHUT_CYC);

  // ---------------------------------------------------------------
  // per-phase command sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    GCF_PH_DEAD = 2'b00,
    GCF_PH_HIGH = 2'b01,
    GCF_PH_LOW  = 2'b10
  } gcf_phase_t;

endpackage

//--- rtl/gcf_phase.sv
`timescale 1ns/1ps
module gcf_phase (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  input  wire logic demand,
  // command pins of one phase
  output logic      hs_cmd,
  output logic      ls_cmd
);

  typedef struct packed {
    gcf_pkg::gcf_phase_t           st;
    logic [gcf_pkg::TMR_W-1:0]     tmr;
    logic                          hs;
    logic                          ls;
  } gcf_ph_state_t;

  gcf_ph_state_t s_r;
  gcf_ph_state_t s_nxt;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // a pulse is never cut short, even by a halt: the hold is far
  // shorter than the time the device allows to reach all-off
  always_comb begin
    s_nxt = s_r;
    if (s_r.tmr != {gcf_pkg::TMR_W{1'b1}}) begin
      s_nxt.tmr = s_r.tmr + gcf_pkg::TMR_ONE;
    end
    unique case (s_r.st)
      gcf_pkg::GCF_PH_DEAD: begin
        if (run && s_r.tmr >= gcf_pkg::DEAD_LAST) begin
          s_nxt.st  = demand ? gcf_pkg::GCF_PH_HIGH : gcf_pkg::GCF_PH_LOW;
          s_nxt.tmr = gcf_pkg::TMR_ZERO;
        end
      end
      gcf_pkg::GCF_PH_HIGH: begin
        if (s_r.tmr >= gcf_pkg::MIN_LAST && (!run || !demand)) begin
          s_nxt.st  = gcf_pkg::GCF_PH_DEAD;
          s_nxt.tmr = gcf_pkg::TMR_ZERO;
        end
      end
      gcf_pkg::GCF_PH_LOW: begin
        if (s_r.tmr >= gcf_pkg::MIN_LAST && (!run || demand)) begin
          s_nxt.st  = gcf_pkg::GCF_PH_DEAD;
          s_nxt.tmr = gcf_pkg::TMR_ZERO;
        end
      end
      default: begin
        s_nxt.st  = gcf_pkg::GCF_PH_DEAD;
        s_nxt.tmr = gcf_pkg::TMR_ZERO;
      end
    endcase
    // never both sides at once, both low in dead time
    s_nxt.hs = (s_nxt.st == gcf_pkg::GCF_PH_HIGH);
    s_nxt.ls = (s_nxt.st == gcf_pkg::GCF_PH_LOW);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: gcf_pkg::GCF_PH_DEAD, tmr: gcf_pkg::TMR_ZERO, hs: 1'b0, ls: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // both pins always driven to a level, never released
  assign hs_cmd = s_r.hs;
  assign ls_cmd = s_r.ls;

endmodule

//--- rtl/gcf_ctrl.sv
// Operation
// - at least 1.5 us dead time and 0.5 us per high or low pulse.
// - carrier period kept at 50 us, so the carrier never exceeds 20 kHz.
// - command pins are always actively driven, never left floating.
// - flag may be mirrored onto high-side shutdown to stop high sides.
// - fault may be mirrored onto high-side shutdown to stop high sides.
// - a requested low-side shutdown pulls the fault line low for 6 us.
// - on a low fault line all commands go low well within 20 us.
`timescale 1ns/1ps
module gcf_ctrl (
  // clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    arst_n,
  // user control
  input  wire logic                                    enable,
  input  wire logic [gcf_pkg::PHASES*gcf_pkg::CNT_W-1:0] duty,
  input  wire logic                                    ls_shutdown_req,
  input  wire logic                                    hs_shutdown_req,
  input  wire logic                                    follow_flag,
  input  wire logic                                    follow_fault,
  input  wire logic                                    fault_clear,
  // user status
  output logic                                         fault_seen,
  output logic                                         running,
  // device command pins
  output logic [gcf_pkg::PHASES-1:0]                   high_side_command,
  output logic [gcf_pkg::PHASES-1:0]                   low_side_command,
  output logic                                         high_side_shutdown_input,
  // device status pins
  input  wire logic                                    overcurrent_limit_flag,
  input  wire logic                                    fault_line_in,
  output logic                                         fault_line_out,
  output logic                                         fault_line_oe_n
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // release is synchronous so no register leaves reset a cycle ahead
  // of its neighbours; assertion stays asynchronous
  assign rst_n = rst_sync_r[1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // every register of this module except rst_sync_r and fault_line_out, written once per clock from s_nxt
  typedef struct packed {
    logic [gcf_pkg::CNT_W-1:0]   carrier;
    logic [gcf_pkg::PHASES-1:0]  demand;
    logic                        fault;
    logic [gcf_pkg::TMR_W-1:0]   shut_cnt;
    logic                        oe_n;
    logic                        sd;
    logic                        run;
  } gcf_ctrl_state_t;

  gcf_ctrl_state_t s_r;
  gcf_ctrl_state_t s_nxt;

  // duty word of one phase; a word at or above the period means full on
  function automatic logic phase_on(input logic [gcf_pkg::CNT_W-1:0] cnt,
                                    input logic [gcf_pkg::CNT_W-1:0] cmp);
    return cnt < cmp;
  endfunction

  // duty word of phase p out of the packed duty bus
  function automatic logic [gcf_pkg::CNT_W-1:0] duty_of(
      input logic [gcf_pkg::PHASES*gcf_pkg::CNT_W-1:0] bus,
      input int                                        p);
    return bus[p*gcf_pkg::CNT_W +: gcf_pkg::CNT_W];
  endfunction

  // a low line counts as a device fault only while this end has let go;
  // during our own pulse the readback says nothing about the device
  function automatic logic line_fault(input logic line,
                                      input logic own_oe_n);
    return !line && own_oe_n;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // ---------------------------------------------------------------
    // carrier
    // ---------------------------------------------------------------
    // sawtooth carrier, one period per 50 us
    if (s_r.carrier >= gcf_pkg::CARRIER_LAST) begin
      s_nxt.carrier = gcf_pkg::CNT_ZERO;
    end else begin
      s_nxt.carrier = s_r.carrier + 11'h001;
    end

    // ---------------------------------------------------------------
    // duty compare
    // ---------------------------------------------------------------
    // registered, so each sequencer sees one clean level per cycle
    for (int i = 0; i < gcf_pkg::PHASES; i++) begin
      s_nxt.demand[i] = phase_on(s_r.carrier, duty_of(duty, i));
    end

    // ---------------------------------------------------------------
    // low-side shutdown pulse
    // ---------------------------------------------------------------
    // pull low, then release for the pull-up
    if (s_r.shut_cnt != gcf_pkg::TMR_ZERO) begin
      s_nxt.shut_cnt = s_r.shut_cnt - gcf_pkg::TMR_ONE;
    end else if (ls_shutdown_req) begin
      s_nxt.shut_cnt = gcf_pkg::SHUT_LOAD;
    end
    s_nxt.oe_n = (s_nxt.shut_cnt == gcf_pkg::TMR_ZERO);

    // ---------------------------------------------------------------
    // fault latch
    // ---------------------------------------------------------------
    // a low line that this end is not pulling is the device's fault;
    // set wins over a clear in the same cycle
    if (line_fault(fault_line_in, s_r.oe_n)) begin
      s_nxt.fault = 1'b1;
    end else if (fault_clear && fault_line_in) begin
      s_nxt.fault = 1'b0;
    end

    // ---------------------------------------------------------------
    // run level
    // ---------------------------------------------------------------
    // halted while faulted or while our own shutdown pulse is out;
    // the device would restart alone, so software decides instead
    s_nxt.run = enable && !s_nxt.fault && s_nxt.oe_n;

    // ---------------------------------------------------------------
    // high-side shutdown pin
    // ---------------------------------------------------------------
    // high-side shutdown is a level held for as long as its cause,
    // so a short glitch of the cause is all the filter can drop
    s_nxt.sd = hs_shutdown_req
            || (follow_flag && overcurrent_limit_flag)
            || (follow_fault && s_nxt.fault);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{
        carrier:  gcf_pkg::CNT_ZERO,
        demand:   3'h0,
        fault:    1'b0,
        shut_cnt: gcf_pkg::TMR_ZERO,
        oe_n:     1'b1,
        sd:       1'b0,
        run:      1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // per-phase sequencers
  // ---------------------------------------------------------------
  // each phase owns its dead time, so no phase can ever present both
  // commands high to a device that would pass them straight through
  for (genvar g = 0; g < gcf_pkg::PHASES; g++) begin : g_phase
    gcf_phase u_phase (
      .clk    (clk),
      .rst_n  (rst_n),
      .run    (s_r.run),
      .demand (s_r.demand[g]),
      .hs_cmd (high_side_command[g]),
      .ls_cmd (low_side_command[g])
    );
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign fault_seen               = s_r.fault;
  assign running                  = s_r.run;
  assign high_side_shutdown_input = s_r.sd;
  assign fault_line_oe_n          = s_r.oe_n;

  // ---------------------------------------------------------------
  // open-drain fault line
  // ---------------------------------------------------------------
  // the driven level is always low; a high level on the line comes
  // only from the pull-up, so this end never fights the device
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_line_out <= 1'b0;
    end else begin
      fault_line_out <= 1'b0;
    end
  end

endmodule

//--- sim/gcf_ctrl_chk.sv
`timescale 1ns/1ps
module gcf_ctrl_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // user side
  input wire logic       ls_shutdown_req,
  input wire logic       hs_shutdown_req,
  input wire logic       fault_clear,
  input wire logic       fault_seen,
  input wire logic       running,
  // device side
  input wire logic [2:0] high_side_command,
  input wire logic [2:0] low_side_command,
  input wire logic       high_side_shutdown_input,
  input wire logic       fault_line_in,
  input wire logic       fault_line_oe_n
);
  logic [1:0] rdy_r;
  logic [5:0] idle_r;
  wire  [2:0] cmd = high_side_command | low_side_command;
  wire        rdy = (rdy_r == 2'h3);
  // inputs count only once the internal reset copy has let go
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_r  <= 2'h0;
      idle_r <= 6'h00;
    end else begin
      rdy_r  <= rdy ? rdy_r : rdy_r + 2'h1;
      idle_r <= cmd[0] ? 6'h00 : ((idle_r == 6'h3f) ? idle_r : idle_r + 6'h01);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_hold;
    high_side_command[0] [*8] ##1 high_side_command[0] [*5];
  endsequence
  sequence s_pulse;
    (!fault_line_oe_n && !running) [*8];
  endsequence
  property p_excl; (high_side_command & low_side_command) == 3'h0; endproperty
  a_excl: assert property (p_excl) else $error("both sides on");
  property p_minhi; $rose(high_side_command[0]) |-> s_hold; endproperty
  a_minhi: assert property (p_minhi) else $error("high pulse short");
  property p_dead; cmd[0] && idle_r != 6'h00 |-> idle_r >= 6'h26; endproperty
  a_dead: assert property (p_dead) else $error("dead time short");
  property p_sd; rdy && hs_shutdown_req |=> high_side_shutdown_input; endproperty
  a_sd: assert property (p_sd) else $error("shutdown pin late");
  property p_flt; rdy && !fault_line_in && fault_line_oe_n |=> fault_seen && !running; endproperty
  a_flt: assert property (p_flt) else $error("fault not taken");
  property p_stop; $rose(fault_seen) |-> ##[0:14] cmd == 3'h0; endproperty
  a_stop: assert property (p_stop) else $error("commands not stopped");
  property p_lsp; rdy && ls_shutdown_req && fault_line_oe_n |=> s_pulse; endproperty
  a_lsp: assert property (p_lsp) else $error("shutdown pulse wrong");
  property p_clr; rdy && fault_clear && fault_line_in |=> !fault_seen; endproperty
  a_clr: assert property (p_clr) else $error("fault not cleared");
endmodule
bind gcf_ctrl gcf_ctrl_chk i_gcf_ctrl_chk (
  .clk(clk), .arst_n(arst_n), .ls_shutdown_req(ls_shutdown_req),
  .hs_shutdown_req(hs_shutdown_req), .fault_clear(fault_clear), .fault_seen(fault_seen),
  .running(running), .high_side_command(high_side_command),
  .low_side_command(low_side_command), .high_side_shutdown_input(high_side_shutdown_input),
  .fault_line_in(fault_line_in), .fault_line_oe_n(fault_line_oe_n));

//--- sim/gcf_dev_model.sv
`timescale 1ns/1ps
module gcf_dev_model (
  // clock and injected faults
  input  wire logic       clk,
  input  wire logic       oc_trip,
  input  wire logic       oc_lim,
  input  wire logic       hot,
  // command and status pins
  input  wire logic [2:0] hcmd,
  input  wire logic [2:0] lcmd,
  input  wire logic       shut,
  input  wire logic       fl,
  output logic            flag,
  output logic            fl_oe_n,
  // gate drives
  output logic [2:0]      hg,
  output logic [2:0]      lg
);
  int         shut_cnt = 0;
  int         hold_cnt = 0;
  logic [2:0] hprev = 3'h0;
  assign flag = oc_lim | oc_trip;
  assign fl_oe_n = !(oc_trip | hot | (hold_cnt > 0));
  assign lg = lcmd & {3{fl === 1'b1}};
  always @(posedge clk) begin
    shut_cnt <= (shut === 1'b1) ? shut_cnt + 1 : 0;
    hold_cnt <= oc_trip ? 625 : ((hold_cnt > 0) ? hold_cnt - 1 : 0);
    hprev <= hcmd;
    for (int i = 0; i < 3; i++) begin
      if (shut_cnt >= 83) hg[i] <= 1'b0;
      else if (hcmd[i] === 1'b1 && hprev[i] !== 1'b1) hg[i] <= 1'b1;
      else if (hcmd[i] !== 1'b1) hg[i] <= 1'b0;
    end
  end
endmodule

//--- sim/gcf_ctrl_tb.sv
`timescale 1ns/1ps
module gcf_ctrl_tb;
  logic clk = 1'b0, arst_n = 1'b0, en = 1'b0, lsr = 1'b0, hsr = 1'b0, ffl = 1'b0;
  logic clr = 1'b0, trip = 1'b0, lim = 1'b0, hot = 1'b0, ffa = 1'b0;
  logic [32:0] duty = 33'h0;
  logic seen, run, sdp, fl, oe_n, fout, flag, dev_oe_n;
  logic [2:0] hsc, lsc, hg, lg;
  int n_errors = 0, n_compared = 0, n;
  // the pull-up wins unless a party pulls low
  assign fl = (oe_n | fout) & dev_oe_n;
  gcf_ctrl i_gcf_ctrl (.clk(clk), .arst_n(arst_n), .enable(en), .duty(duty),
    .ls_shutdown_req(lsr), .hs_shutdown_req(hsr), .follow_flag(ffl), .follow_fault(ffa),
    .fault_clear(clr), .fault_seen(seen), .running(run), .high_side_command(hsc),
    .low_side_command(lsc), .high_side_shutdown_input(sdp), .overcurrent_limit_flag(flag),
    .fault_line_in(fl), .fault_line_out(fout), .fault_line_oe_n(oe_n));
  gcf_dev_model i_gcf_dev_model (.clk(clk), .oc_trip(trip), .oc_lim(lim), .hot(hot),
    .hcmd(hsc), .lcmd(lsc), .shut(sdp), .fl(fl), .flag(flag), .fl_oe_n(dev_oe_n),
    .hg(hg), .lg(lg));
  initial forever #20 clk = ~clk;
  task automatic w(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(string s, logic [10:0] e, logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask
  task automatic wt(logic v);
    while (hsc[0] !== v) begin
      w(1);
      n++;
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_run();
    @(posedge clk);
    en <= 1'b1;
    duty <= {11'h4e2, 11'h000, 11'h258};
    w(2600);
    chk("running", 1, run);
    chk("high cmds", 3'h4, hsc & 3'h6);
    chk("low cmds", 3'h2, lsc & 3'h6);
    chk("high gates", 3'h4, hg & 3'h6);
    chk("low gates", 3'h2, lg & 3'h6);
    wt(0);
    wt(1);
    n = 0;
    wt(0);
    wt(1);
    chk("carrier", 11'h4e2, 11'(n));
    $display("run done");
  endtask
  task automatic t_shut();
    @(posedge clk);
    hsr <= 1'b1;
    w(100);
    chk("shutdown pin", 1, sdp);
    chk("high gates off", 0, hg);
    @(posedge clk);
    hsr <= 1'b0;
    w(100);
    chk("shutdown pin", 0, sdp);
    chk("gate waits edge", 0, hg[2]);
    @(posedge clk);
    ffl <= 1'b1;
    lim <= 1'b1;
    w(3);
    chk("flag", 1, flag);
    chk("flag to shutdown", 1, sdp);
    @(posedge clk);
    lim <= 1'b0;
    w(3);
    chk("flag to shutdown", 0, sdp);
    $display("shut done");
  endtask
  task automatic t_lsp();
    @(posedge clk);
    lsr <= 1'b1;
    @(posedge clk);
    lsr <= 1'b0;
    n = 0;
    w(1);
    chk("low gates off", 0, lg);
    chk("running", 0, run);
    while (fl === 1'b0) begin
      n++;
      w(1);
    end
    chk("pulse length", 11'h096, 11'(n));
    w(2);
    chk("own pulse", 0, seen);
    $display("low shutdown done");
  endtask
  task automatic t_trip(bit oc);
    @(posedge clk);
    ffa <= !oc;
    if (oc) trip <= 1'b1;
    else hot <= 1'b1;
    repeat (10) @(posedge clk);
    trip <= 1'b0;
    hot <= 1'b0;
    n = 10;
    w(1);
    while (fl === 1'b0) begin
      n++;
      w(1);
    end
    chk("fault length", oc ? 11'h27b : 11'h00a, 11'(n));
    chk("fault latched", 1, seen);
    chk("fault to shutdown", !oc, sdp);
    w(10);
    chk("commands off", 3'h0, hsc | lsc);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    w(100);
    chk("fault cleared", 0, seen);
    chk("shutdown released", 0, sdp);
    chk("gate after edge", 1, hg[2]);
    $display("trip done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_run();
    t_shut();
    t_lsp();
    t_trip(1'b1);
    t_trip(1'b0);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
